// [rtl/ddcp_pkg.sv]
// Constants, field layouts and carrier types for the configuration page registers.
// Assumes a single core clock domain; all users reference items as ddcp_pkg::name.
`default_nettype none
package ddcp_pkg;
    // Register offsets in the command address space
    localparam logic [7:0] REG_CLK_HI  = 8'hF6;
    localparam logic [7:0] REG_CLK_LO  = 8'hF7;
    localparam logic [7:0] REG_I2C     = 8'hF8;
    localparam logic [7:0] REG_PIX     = 8'hF9;
    localparam logic [7:0] REG_RELOAD  = 8'hFB;
    localparam logic [7:0] REG_STATUS  = 8'hFE;
    localparam logic [7:0] REG_PAGE    = 8'hFF;

    // Field positions
    localparam int         CLK_SEL_BIT = 0;
    localparam int         FREQ_HI_LSB = 4;

    // Reset values
    localparam logic        CLK_SEL_RST  = 1'b0;
    localparam logic [11:0] CLK_FREQ_RST = 12'h578;
    localparam logic [6:0]  I2C_ADDR_RST = 7'h00;
    localparam logic [1:0]  PIX_FMT_RST  = 2'h0;
    localparam logic        RELOAD_RST   = 1'b0;
    localparam logic [7:0]  RD_IDLE      = 8'h00;

    // Address always answered on the serial bus
    localparam logic [6:0]  I2C_GLOBAL_ADDR = 7'h00;
    // Highest legal page select value
    localparam logic [7:0]  PAGE_VAL_MAX    = 8'h05;

    // External clock range and scale of the frequency code
    localparam int          FREQ_MIN_MHZ  = 9;
    localparam int          FREQ_MAX_MHZ  = 40;
    localparam int          FREQ_SCALE    = 100;
    localparam logic [11:0] FREQ_CODE_MIN = 12'(FREQ_MIN_MHZ * FREQ_SCALE);
    localparam logic [11:0] FREQ_CODE_MAX = 12'(FREQ_MAX_MHZ * FREQ_SCALE);

    // Component widening modes
    localparam logic [1:0]  WIDEN_REPEAT = 2'h0;
    localparam logic [1:0]  WIDEN_ZERO   = 2'h1;
    localparam logic [1:0]  WIDEN_ONE    = 2'h2;

    // Incoming pixel packing
    typedef enum logic [1:0] {
        FMT_565 = 2'h0,
        FMT_666 = 2'h1,
        FMT_888 = 2'h2
    } ddcp_fmt_t;

    // Register page, one-hot; the code is also the status readback
    typedef enum logic [5:0] {
        PG_SET1 = 6'h01,
        PG_P0   = 6'h02,
        PG_P1   = 6'h04,
        PG_P2   = 6'h08,
        PG_P3   = 6'h10,
        PG_P4   = 6'h20
    } ddcp_page_t;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } ddcp_pixel_t;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] data;
    } ddcp_cmd_t;

    // Nonvolatile image of the reloadable registers
    typedef struct packed {
        logic        valid;
        logic        clk_sel;
        logic [11:0] freq;
        logic [1:0]  pix_fmt;
    } ddcp_nv_t;
endpackage
`default_nettype wire

// [rtl/ddcp_regs.sv]
// Configuration page register bank: clock source, target address, pixel widening,
// sleep-exit reload and page select. Assumes command strobes come from the serial
// command decoder in the core clock domain and pixels arrive synchronous to it.
`default_nettype none

// Functional notes
// - Clock source select 0 uses internal oscillator, 1 uses the external clock.
// - Frequency code holds 100 times external MHz; accepted range 9 to 40 MHz.
// - Mode 00 widens components by repeating their upper bits.
// - Mode 01 widens components by appending zero bits.
// - Mode 10 widens components by appending one bits.
// - 24-bit pixels pass unchanged; mode 11 is not a valid setting (the bank stores it and widens as mode 00, repeating upper bits).
// - Reload bit 0 restores clock select, frequency code and widening mode on sleep exit; 1 keeps them.
// - After reset, reloadable registers take nonvolatile value else default.
// - Status readback is one-hot: bit 0 set one, bits 1-5 pages 0-4.
// - Page select 00h is set one, 01h to 05h set-two pages 0 to 4.
// - Page select takes effect at once for following accesses.
module ddcp_regs (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 cmd_valid,
    input  wire ddcp_pkg::ddcp_cmd_t  cmd,
    input  wire logic                 i2c_addr_valid,
    input  wire logic [6:0]           i2c_addr,
    input  wire logic                 soft_reset,
    input  wire logic                 sleep_exit,
    input  wire ddcp_pkg::ddcp_nv_t   nv,
    input  wire logic                 pix_valid,
    input  wire ddcp_pkg::ddcp_fmt_t  pix_fmt,
    input  wire ddcp_pkg::ddcp_pixel_t pix_in,
    output logic                      rd_valid,
    output logic [7:0]                rd_data,
    output logic                      i2c_addr_ack,
    output logic                      ext_clock_select,
    output logic [11:0]               ext_clock_freq_code,
    output logic                      ext_clock_freq_ok,
    output ddcp_pkg::ddcp_page_t      cur_page,
    output logic                      pix_out_valid,
    output ddcp_pkg::ddcp_pixel_t     pix_out
);

    // Page decode of a select value
    function automatic ddcp_pkg::ddcp_page_t page_decode(input logic [7:0] v);
        unique case (v)
            8'h00:   page_decode = ddcp_pkg::PG_SET1;
            8'h01:   page_decode = ddcp_pkg::PG_P0;
            8'h02:   page_decode = ddcp_pkg::PG_P1;
            8'h03:   page_decode = ddcp_pkg::PG_P2;
            8'h04:   page_decode = ddcp_pkg::PG_P3;
            8'h05:   page_decode = ddcp_pkg::PG_P4;
            default: page_decode = ddcp_pkg::PG_SET1;
        endcase
    endfunction

    // Widen a 5-bit component held in c[4:0]
    function automatic logic [7:0] widen5(input logic [7:0] c, input logic [1:0] mode);
        unique case (mode)
            ddcp_pkg::WIDEN_ZERO: widen5 = {c[4:0], 3'h0};
            ddcp_pkg::WIDEN_ONE:  widen5 = {c[4:0], 3'h7};
            default:              widen5 = {c[4:0], c[4:2]};
        endcase
    endfunction

    // Widen a 6-bit component held in c[5:0]
    function automatic logic [7:0] widen6(input logic [7:0] c, input logic [1:0] mode);
        unique case (mode)
            ddcp_pkg::WIDEN_ZERO: widen6 = {c[5:0], 2'h0};
            ddcp_pkg::WIDEN_ONE:  widen6 = {c[5:0], 2'h3};
            default:              widen6 = {c[5:0], c[5:4]};
        endcase
    endfunction

    logic                 clk_sel_q,  clk_sel_d;
    logic [11:0]          freq_q,     freq_d;
    logic                 freq_ok_q,  freq_ok_d;
    logic [6:0]           i2c_q,      i2c_d;
    logic [1:0]           pix_mode_q, pix_mode_d;
    logic                 reload_q,   reload_d;
    logic                 load_q,     load_d;
    ddcp_pkg::ddcp_page_t page_q,     page_d;
    logic                 wr_set1;

    // Configuration state: host writes, page switching, reset and sleep-exit reloads
    always_comb begin
        clk_sel_d  = clk_sel_q;
        freq_d     = freq_q;
        i2c_d      = i2c_q;
        pix_mode_d = pix_mode_q;
        reload_d   = reload_q;
        page_d     = page_q;
        load_d     = 1'b0;
        wr_set1    = cmd_valid && cmd.write && (page_q == ddcp_pkg::PG_SET1);
        if (cmd_valid && cmd.write && cmd.addr == ddcp_pkg::REG_PAGE &&
            cmd.data <= ddcp_pkg::PAGE_VAL_MAX) begin
            page_d = page_decode(cmd.data);
        end
        if (wr_set1) begin
            unique case (cmd.addr)
                ddcp_pkg::REG_CLK_HI: begin
                    clk_sel_d    = cmd.data[ddcp_pkg::CLK_SEL_BIT];
                    freq_d[11:8] = cmd.data[ddcp_pkg::FREQ_HI_LSB +: 4];
                end
                ddcp_pkg::REG_CLK_LO: freq_d[7:0] = cmd.data;
                ddcp_pkg::REG_I2C:    i2c_d       = cmd.data[6:0];
                ddcp_pkg::REG_PIX:    pix_mode_d  = cmd.data[1:0];
                ddcp_pkg::REG_RELOAD: reload_d    = cmd.data[0];
                default: ;
            endcase
        end
        // Pending reload overrides a host write of clock select, frequency code or widening mode in the same cycle
        if (load_q) begin
            clk_sel_d  = nv.valid ? nv.clk_sel : ddcp_pkg::CLK_SEL_RST;
            freq_d     = nv.valid ? nv.freq    : ddcp_pkg::CLK_FREQ_RST;
            pix_mode_d = nv.valid ? nv.pix_fmt : ddcp_pkg::PIX_FMT_RST;
        end
        if (sleep_exit && !reload_q) begin
            load_d = 1'b1;
        end
        if (soft_reset) begin
            i2c_d    = ddcp_pkg::I2C_ADDR_RST;
            reload_d = ddcp_pkg::RELOAD_RST;
            page_d   = ddcp_pkg::PG_SET1;
            load_d   = 1'b1;
        end
        freq_ok_d = (freq_d >= ddcp_pkg::FREQ_CODE_MIN) &&
                    (freq_d <= ddcp_pkg::FREQ_CODE_MAX);
    end

    // Reset leaves a load pending so the nonvolatile image is taken after release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_sel_q  <= ddcp_pkg::CLK_SEL_RST;
            freq_q     <= ddcp_pkg::CLK_FREQ_RST;
            freq_ok_q  <= 1'b1;
            i2c_q      <= ddcp_pkg::I2C_ADDR_RST;
            pix_mode_q <= ddcp_pkg::PIX_FMT_RST;
            reload_q   <= ddcp_pkg::RELOAD_RST;
            load_q     <= 1'b1;
            page_q     <= ddcp_pkg::PG_SET1;
        end else begin
            clk_sel_q  <= clk_sel_d;
            freq_q     <= freq_d;
            freq_ok_q  <= freq_ok_d;
            i2c_q      <= i2c_d;
            pix_mode_q <= pix_mode_d;
            reload_q   <= reload_d;
            load_q     <= load_d;
            page_q     <= page_d;
        end
    end

    logic       rd_valid_q, rd_valid_d;
    logic [7:0] rd_data_q,  rd_data_d;
    logic       ack_q,      ack_d;

    // Read answers and serial address match
    always_comb begin
        rd_valid_d = cmd_valid && !cmd.write;
        rd_data_d  = ddcp_pkg::RD_IDLE;
        if (cmd_valid && !cmd.write) begin
            if (cmd.addr == ddcp_pkg::REG_STATUS) begin
                rd_data_d = {2'h0, page_q};
            end else if (page_q == ddcp_pkg::PG_SET1) begin
                unique case (cmd.addr)
                    ddcp_pkg::REG_CLK_HI: rd_data_d = {freq_q[11:8], 3'h0, clk_sel_q};
                    ddcp_pkg::REG_CLK_LO: rd_data_d = freq_q[7:0];
                    ddcp_pkg::REG_I2C:    rd_data_d = {1'b0, i2c_q};
                    ddcp_pkg::REG_PIX:    rd_data_d = {6'h00, pix_mode_q};
                    ddcp_pkg::REG_RELOAD: rd_data_d = {7'h00, reload_q};
                    default:              rd_data_d = ddcp_pkg::RD_IDLE;
                endcase
            end
        end
        ack_d = i2c_addr_valid && (i2c_addr == ddcp_pkg::I2C_GLOBAL_ADDR ||
                                   i2c_addr == i2c_q);
    end

    // Response registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= ddcp_pkg::RD_IDLE;
            ack_q      <= 1'b0;
        end else begin
            rd_valid_q <= rd_valid_d;
            rd_data_q  <= rd_data_d;
            ack_q      <= ack_d;
        end
    end

    logic                  pv_q, pv_d;
    ddcp_pkg::ddcp_pixel_t px_q, px_d;

    // Pixel component widening, one cycle latency
    always_comb begin
        pv_d = pix_valid;
        px_d = px_q;
        if (pix_valid) begin
            unique case (pix_fmt)
                ddcp_pkg::FMT_565: begin
                    px_d.r = widen5(pix_in.r, pix_mode_q);
                    px_d.g = widen6(pix_in.g, pix_mode_q);
                    px_d.b = widen5(pix_in.b, pix_mode_q);
                end
                ddcp_pkg::FMT_666: begin
                    px_d.r = widen6(pix_in.r, pix_mode_q);
                    px_d.g = widen6(pix_in.g, pix_mode_q);
                    px_d.b = widen6(pix_in.b, pix_mode_q);
                end
                default: px_d = pix_in;
            endcase
        end
    end

    // Pixel output registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pv_q <= 1'b0;
            px_q <= '0;
        end else begin
            pv_q <= pv_d;
            px_q <= px_d;
        end
    end

    // Outputs straight from flip-flops
    assign rd_valid            = rd_valid_q;
    assign rd_data             = rd_data_q;
    assign i2c_addr_ack        = ack_q;
    assign ext_clock_select    = clk_sel_q;
    assign ext_clock_freq_code = freq_q;
    assign ext_clock_freq_ok   = freq_ok_q;
    assign cur_page            = page_q;
    assign pix_out_valid       = pv_q;
    assign pix_out             = px_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence page_wr_s;
        cmd_valid && cmd.write && cmd.addr == ddcp_pkg::REG_PAGE &&
        cmd.data <= ddcp_pkg::PAGE_VAL_MAX && !soft_reset;
    endsequence
    sequence soft_load_s;
        soft_reset ##1 (!nv.valid && !(cmd_valid && cmd.write));
    endsequence
    sequence p565_s(logic [1:0] m);
        pix_valid && pix_fmt == ddcp_pkg::FMT_565 && pix_mode_q == m;
    endsequence

    page_switch_a: assert property (page_wr_s |=> page_q == page_decode($past(cmd.data)))
        else $error("page select not applied");
    status_onehot_a: assert property ($onehot(page_q))
        else $error("page status not one-hot");
    status_read_a: assert property (cmd_valid && !cmd.write && cmd.addr == ddcp_pkg::REG_STATUS
        |=> rd_valid && rd_data == {2'h0, $past(page_q)})
        else $error("status readback wrong");
    addr_top_a: assert property (cmd_valid && !cmd.write && cmd.addr == ddcp_pkg::REG_I2C
        |=> rd_data[7] == 1'b0)
        else $error("address register top bit set");
    global_ack_a: assert property (i2c_addr_valid && i2c_addr == ddcp_pkg::I2C_GLOBAL_ADDR
        |=> i2c_addr_ack)
        else $error("global address not acknowledged");
    widen_rep_a: assert property (p565_s(ddcp_pkg::WIDEN_REPEAT)
        |=> pix_out.r[2:0] == $past(pix_in.r[4:2]) && pix_out.g[1:0] == $past(pix_in.g[5:4]))
        else $error("repeat widening wrong");
    widen_zero_a: assert property (p565_s(ddcp_pkg::WIDEN_ZERO)
        |=> pix_out.r[2:0] == 3'h0 && pix_out.g[1:0] == 2'h0)
        else $error("zero widening wrong");
    widen_one_a: assert property (p565_s(ddcp_pkg::WIDEN_ONE)
        |=> pix_out.b[2:0] == 3'h7 && pix_out.g[1:0] == 2'h3)
        else $error("one widening wrong");
    pass_888_a: assert property (pix_valid && pix_fmt == ddcp_pkg::FMT_888
        |=> pix_out_valid && pix_out == $past(pix_in))
        else $error("24-bit pixel altered");
    soft_default_a: assert property (soft_load_s
        |=> ext_clock_freq_code == ddcp_pkg::CLK_FREQ_RST && !ext_clock_select)
        else $error("reset reload wrong");
    reload_keep_a: assert property (sleep_exit && reload_q && !soft_reset && !load_q
        && !cmd_valid ##1 !cmd_valid |=> $stable(freq_q) && $stable(pix_mode_q))
        else $error("registers reloaded while reload off");
    clk_sel_wr_a: assert property (cmd_valid && cmd.write && cmd.addr == ddcp_pkg::REG_CLK_HI
        && page_q == ddcp_pkg::PG_SET1 && !load_q
        |=> ext_clock_select == $past(cmd.data[0]))
        else $error("clock select not written");

endmodule
`default_nettype wire

// [sim/ddcp_host_model.sv]
// Host side model: issues one register command at a time on the strobe port.
// Assumes the bench calls access() from a single process.
`default_nettype none
module ddcp_host_model (
    input  wire logic           core_clk,
    output logic                cmd_valid,
    output ddcp_pkg::ddcp_cmd_t cmd,
    input  wire logic           rd_valid,
    input  wire logic [7:0]     rd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // One access, held for one edge; answer sampled in the following cycle
    // Only issued while the display is in normal, idle off, sleep out or sleep
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic got);
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd       = {w, a, d};
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        cmd       = ~cmd; // Released bus must not keep its last value
        got       = rd_valid;
        q         = rd_data;
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the configuration page register bank.
// Assumes a 20 MHz core clock and the host model on the command port.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  core_clk, rst, cmd_valid, i2c_addr_valid, i2c_addr_ack;
    logic                  soft_reset, sleep_exit, pix_valid, pix_out_valid, rd_valid;
    logic                  ext_clock_select, ext_clock_freq_ok;
    logic [6:0]            i2c_addr;
    logic [7:0]            rd_data, q;
    logic [11:0]           ext_clock_freq_code;
    logic                  got;
    ddcp_pkg::ddcp_cmd_t   cmd;
    ddcp_pkg::ddcp_nv_t    nv;
    ddcp_pkg::ddcp_fmt_t   pix_fmt;
    ddcp_pkg::ddcp_pixel_t pix_in, pix_out;
    ddcp_pkg::ddcp_page_t  cur_page;
    int                    n_errors, check_count;
    // Frequency codes already rounded to hundredths, with expected range flag
    logic [12:0]           freq_tbl [5] = '{13'h0383, 13'h1384, 13'h1586, 13'h1FA0, 13'h0FA1};

    ddcp_regs dut_u (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .i2c_addr_valid(i2c_addr_valid), .i2c_addr(i2c_addr), .soft_reset(soft_reset),
        .sleep_exit(sleep_exit), .nv(nv), .pix_valid(pix_valid), .pix_fmt(pix_fmt),
        .pix_in(pix_in), .rd_valid(rd_valid), .rd_data(rd_data),
        .i2c_addr_ack(i2c_addr_ack), .ext_clock_select(ext_clock_select),
        .ext_clock_freq_code(ext_clock_freq_code), .ext_clock_freq_ok(ext_clock_freq_ok),
        .cur_page(cur_page), .pix_out_valid(pix_out_valid), .pix_out(pix_out));

    ddcp_host_model host_u (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .rd_valid(rd_valid), .rd_data(rd_data));

    // Clock generation
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d, q, got);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_u.access(1'b0, a, 8'h00, q, got);
        chk(24'(got), 24'h000001);
        chk(24'(q), 24'(exp));
    endtask

    // One-cycle pulse on a control input; returns while the load cycle is still pending
    task automatic pulse(ref logic s);
        @(posedge core_clk);
        #1 s = 1'b1;
        @(posedge core_clk);
        #1 s = 1'b0;
    endtask

    task automatic addr_chk(input logic [6:0] a, input logic exp);
        @(posedge core_clk);
        #1 i2c_addr_valid = 1'b1;
        i2c_addr = a;
        @(posedge core_clk);
        #1 i2c_addr_valid = 1'b0;
        i2c_addr = ~a;
        chk(24'(i2c_addr_ack), 24'(exp));
    endtask

    // Expected widened component for a given source width and mode
    function automatic logic [7:0] widen(input logic [7:0] v, input int w, input int m);
        if (w == 8) return v;
        if (w == 5) return (m == 1) ? {v[4:0], 3'h0} : (m == 2) ? {v[4:0], 3'h7}
                                                                : {v[4:0], v[4:2]};
        return (m == 1) ? {v[5:0], 2'h0} : (m == 2) ? {v[5:0], 2'h3} : {v[5:0], v[5:4]};
    endfunction

    task automatic pix_chk(input int f, input int m);
        int w5;
        w5 = (f == 0) ? 5 : (f == 1) ? 6 : 8;
        @(posedge core_clk);
        #1 pix_valid = 1'b1;
        pix_fmt = ddcp_pkg::ddcp_fmt_t'(f);
        pix_in  = 24'hA56BCD;
        @(posedge core_clk);
        #1 pix_valid = 1'b0;
        pix_in = 24'h5A9432;
        chk(24'(pix_out_valid), 24'h000001);
        chk(pix_out, {widen(8'hA5, w5, m), widen(8'h6B, (f == 2) ? 8 : 6, m),
                      widen(8'hCD, w5, m)});
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        rst = 1'b1; i2c_addr_valid = 1'b0; i2c_addr = 7'h00;
        soft_reset = 1'b0; sleep_exit = 1'b0; pix_valid = 1'b0; pix_in = '0;
        pix_fmt = ddcp_pkg::FMT_565; nv = '0; n_errors = 0; check_count = 0;
        repeat (4) @(posedge core_clk);
        #1 rst = 1'b0;
        rd_chk(8'hF6, 8'h50);
        rd_chk(8'hF7, 8'h78);
        rd_chk(8'hF8, 8'h00);
        rd_chk(8'hF9, 8'h00);
        rd_chk(8'hFB, 8'h00);
        rd_chk(8'hFE, 8'h01);
        rd_chk(8'hFF, 8'h00);
        $display("test reset done");
        wr(8'hF6, 8'h71);
        wr(8'hF7, 8'hD0);
        chk(24'(ext_clock_select), 24'h000001);
        chk(24'(ext_clock_freq_code), 24'h0007D0);
        wr(8'hF6, 8'h70);
        chk(24'(ext_clock_select), 24'h000000);
        foreach (freq_tbl[i]) begin
            wr(8'hF6, {freq_tbl[i][11:8], 4'h0});
            wr(8'hF7, freq_tbl[i][7:0]);
            chk(24'(ext_clock_freq_ok), 24'(freq_tbl[i][12]));
        end
        $display("test clock done");
        wr(8'hF8, 8'hFF);
        rd_chk(8'hF8, 8'h7F);
        wr(8'hF8, 8'h5A);
        rd_chk(8'hF8, 8'h5A);
        addr_chk(7'h00, 1'b1);
        addr_chk(7'h5A, 1'b1);
        addr_chk(7'h12, 1'b0);
        // Plain address bytes only, no hardware general call
        $display("test address done");
        for (int m = 0; m < 4; m++) begin
            wr(8'hF9, 8'(m));
            for (int f = 0; f < 3; f++) pix_chk(f, m);
        end
        $display("test pixel done");
        for (int p = 0; p < 6; p++) begin
            wr(8'hFF, 8'(p));
            chk(24'(cur_page), 24'(1 << p));
            rd_chk(8'hFE, 8'(1 << p));
        end
        rd_chk(8'hF8, 8'h00);
        wr(8'hFF, 8'h03);
        wr(8'hFF, 8'h06);
        rd_chk(8'hFE, 8'h08);
        wr(8'hFF, 8'h00);
        rd_chk(8'hF8, 8'h5A);
        $display("test page done");
        nv = {1'b1, 1'b1, 12'h9C4, 2'h2};
        wr(8'hF6, 8'h30);
        wr(8'hF9, 8'h01);
        wr(8'hFB, 8'h00);
        pulse(sleep_exit);
        rd_chk(8'hF6, 8'h91);
        rd_chk(8'hF7, 8'hC4);
        rd_chk(8'hF9, 8'h02);
        wr(8'hFB, 8'h01);
        wr(8'hF7, 8'h55);
        pulse(sleep_exit);
        rd_chk(8'hF7, 8'h55);
        wr(8'hFF, 8'h02);
        pulse(soft_reset);
        rd_chk(8'hF7, 8'hC4);
        rd_chk(8'hFB, 8'h00);
        rd_chk(8'hF8, 8'h00);
        rd_chk(8'hFE, 8'h01);
        nv.valid = 1'b0;
        pulse(soft_reset);
        rd_chk(8'hF6, 8'h50);
        rd_chk(8'hF7, 8'h78);
        // Hardware reset in mid-run takes the programmed nonvolatile image
        nv.valid = 1'b1;
        @(posedge core_clk);
        #1 rst = 1'b1;
        @(posedge core_clk);
        #1 rst = 1'b0;
        rd_chk(8'hF6, 8'h91);
        rd_chk(8'hF7, 8'hC4);
        $display("test reload done");
        print_verdict();
    end
endmodule
`default_nettype wire
